// ---- pkg/rcr_pkg.sv ----
// Constants and carrier types for the rail control register bank.
// Assumes an APB master on pclk and an asynchronous standby pin.
// Function
// - I/O rail register at 0x30, reset 0x0A, bit 7 reserved reads zero.
// - Decay bit set and standby low lets I/O rail decay, power-good kept good.
// - I/O voltage select bits 5:4 decode 0.975/0.950/0.875/0.850 V, reset 00.
// - Standby rising edge copies nonzero exit-mode bits 3:2 into mode bits 1:0.
// - Mode bits 1:0: 00 disabled, 01/10 automatic, 11 forced PWM.
// - 5 V standby rail register at 0x31, reset 0x2A, all bits writable.
// - Standby asserted applies low set point 7:6: -4%, -3%, -2%, 00 keeps normal.
// - Normal select 5:4 decodes +3%, +2%, nominal, -2% for codes 00 to 11.
// - 3.3 V deep-sleep rail register at 0x32, reset 0x2A, all writable.
// - 3.3 V register uses the same field layout as the 5 V register.
package rcr_pkg;
  localparam logic [7:0] IO_RAIL_CONTROL_OFFSET = 8'h30;
  localparam logic [7:0] STANDBY_5V_RAIL_CONTROL_OFFSET = 8'h31;
  localparam logic [7:0] DEEP_SLEEP_3V3_RAIL_CONTROL_OFFSET = 8'h32;
  localparam logic [7:0] IO_RAIL_RESET = 8'h0A;
  localparam logic [7:0] STANDBY_5V_RESET = 8'h2A;
  localparam logic [7:0] DEEP_SLEEP_3V3_RESET = 8'h2A;
  localparam logic [7:0] IO_RAIL_WRITE_MASK = 8'h7F;
  localparam logic [1:0] MODE_DISABLED = 2'h0;
  localparam logic [1:0] MODE_FORCED_PWM = 2'h3;
  localparam logic [1:0] EXIT_NO_CHANGE = 2'h0;
  localparam logic [1:0] LOW_SETPOINT_OFF = 2'h0;
  // Regulator reference codes: percent offset from nominal, signed
  localparam logic signed [3:0] PCT_PLUS3 = 4'sh3;
  localparam logic signed [3:0] PCT_PLUS2 = 4'sh2;
  localparam logic signed [3:0] PCT_NOM = 4'sh0;
  localparam logic signed [3:0] PCT_MINUS2 = -4'sh2;
  localparam logic signed [3:0] PCT_MINUS3 = -4'sh3;
  localparam logic signed [3:0] PCT_MINUS4 = -4'sh4;
  // I/O rail targets in millivolts
  localparam logic [9:0] IO_MV_0975 = 10'h3CF;
  localparam logic [9:0] IO_MV_0950 = 10'h3B6;
  localparam logic [9:0] IO_MV_0875 = 10'h36B;
  localparam logic [9:0] IO_MV_0850 = 10'h352;
  localparam logic [9:0] IO_MV_ZERO = 10'h000;
  localparam logic [7:0] APB_ADDR_MASK = 8'hFF;

  typedef struct packed {
    logic [1:0] low_setpoint;
    logic [1:0] voltage_select;
    logic [1:0] exit_mode;
    logic [1:0] mode;
  } rcr_rail_type;

  typedef struct packed {
    logic enable;
    logic auto_mode;
    logic forced_pulse_width_mode;
  } rcr_mode_type;
endpackage : rcr_pkg

// ---- core/rcr_mode_decode.sv ----
// Decodes a two-bit converter mode into enable and operating mode flags.
// Assumes a registered mode field from the same clock domain.
module rcr_mode_decode (
  input wire logic [1:0] mode,
  output rcr_pkg::rcr_mode_type decoded
);
  always_comb
  begin
    decoded.enable = (mode != rcr_pkg::MODE_DISABLED);
    decoded.forced_pulse_width_mode = (mode == rcr_pkg::MODE_FORCED_PWM);
    decoded.auto_mode = decoded.enable && !decoded.forced_pulse_width_mode;
  end
endmodule : rcr_mode_decode

// ---- core/rcr_bank.sv ----
// Three rail control registers on APB with standby set point and exit logic.
// Assumes APB3 on pclk; standby_request_n is an asynchronous pin.
module rcr_bank (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic standby_request_n,
  output logic [9:0] io_rail_target_mv,
  output logic io_rail_power_good_hold,
  output logic signed [3:0] standby_5v_offset_pct,
  output logic signed [3:0] deep_sleep_3v3_offset_pct,
  output rcr_pkg::rcr_mode_type io_rail_mode_out,
  output rcr_pkg::rcr_mode_type standby_5v_mode_out,
  output rcr_pkg::rcr_mode_type deep_sleep_3v3_mode_out
);
  logic [7:0] io_rail_control;
  rcr_pkg::rcr_rail_type standby_5v_rail_control;
  rcr_pkg::rcr_rail_type deep_sleep_3v3_rail_control;
  logic [7:0] next_io_rail_control;
  rcr_pkg::rcr_rail_type next_standby_5v_rail_control;
  rcr_pkg::rcr_rail_type next_deep_sleep_3v3_rail_control;
  logic sync_first;
  logic sync_second;
  logic standby_seen;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [9:0] next_io_target;
  logic next_io_pg_hold;
  logic signed [3:0] next_5v_offset;
  logic signed [3:0] next_3v3_offset;
  logic exit_edge;
  logic standby_active;
  logic access;
  logic [7:0] word_addr;
  rcr_pkg::rcr_mode_type io_dec;
  rcr_pkg::rcr_mode_type s5_dec;
  rcr_pkg::rcr_mode_type d3_dec;

  // Exit-mode field replaces the mode bits only when nonzero
  function automatic logic [1:0] apply_exit(input logic [1:0] mode, input logic [1:0] exit_mode);
    apply_exit = (exit_mode == rcr_pkg::EXIT_NO_CHANGE) ? mode : exit_mode;
  endfunction : apply_exit

  // Normal select, or the low set point while standby is asserted
  function automatic logic signed [3:0] rail_offset(input rcr_pkg::rcr_rail_type r,
                                                    input logic standby);
    logic signed [3:0] pct;
    pct = rcr_pkg::PCT_NOM;
    case (r.voltage_select)
      2'h0: pct = rcr_pkg::PCT_PLUS3;
      2'h1: pct = rcr_pkg::PCT_PLUS2;
      2'h2: pct = rcr_pkg::PCT_NOM;
      default: pct = rcr_pkg::PCT_MINUS2;
    endcase
    if (standby && r.low_setpoint != rcr_pkg::LOW_SETPOINT_OFF)
    begin
      case (r.low_setpoint)
        2'h1: pct = rcr_pkg::PCT_MINUS4;
        2'h2: pct = rcr_pkg::PCT_MINUS3;
        default: pct = rcr_pkg::PCT_MINUS2;
      endcase
    end
    rail_offset = pct;
  endfunction : rail_offset

  // Two-stage synchroniser, then edge detect on the second stage only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_first <= 1'b1;
      sync_second <= 1'b1;
      standby_seen <= 1'b1;
    end
    else
    begin
      sync_first <= standby_request_n;
      sync_second <= sync_first;
      standby_seen <= sync_second;
    end
  end

  assign exit_edge = sync_second && !standby_seen;
  assign standby_active = !sync_second;
  assign access = psel && penable;
  assign word_addr = paddr[9:2] & rcr_pkg::APB_ADDR_MASK;

  always_comb
  begin
    next_io_rail_control = io_rail_control;
    next_standby_5v_rail_control = standby_5v_rail_control;
    next_deep_sleep_3v3_rail_control = deep_sleep_3v3_rail_control;
    if (exit_edge)
    begin
      next_io_rail_control[1:0] = apply_exit(io_rail_control[1:0], io_rail_control[3:2]);
      next_standby_5v_rail_control.mode = apply_exit(standby_5v_rail_control.mode,
                                                     standby_5v_rail_control.exit_mode);
      next_deep_sleep_3v3_rail_control.mode = apply_exit(deep_sleep_3v3_rail_control.mode,
                                                         deep_sleep_3v3_rail_control.exit_mode);
    end
    // A bus write in the same cycle as the exit edge wins over the copy
    if (access && pwrite)
    begin
      case (word_addr)
        rcr_pkg::IO_RAIL_CONTROL_OFFSET:
          next_io_rail_control = pwdata[7:0] & rcr_pkg::IO_RAIL_WRITE_MASK;
        rcr_pkg::STANDBY_5V_RAIL_CONTROL_OFFSET:
          next_standby_5v_rail_control = pwdata[7:0];
        rcr_pkg::DEEP_SLEEP_3V3_RAIL_CONTROL_OFFSET:
          next_deep_sleep_3v3_rail_control = pwdata[7:0];
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      io_rail_control <= rcr_pkg::IO_RAIL_RESET;
      standby_5v_rail_control <= rcr_pkg::STANDBY_5V_RESET;
      deep_sleep_3v3_rail_control <= rcr_pkg::DEEP_SLEEP_3V3_RESET;
    end
    else
    begin
      io_rail_control <= next_io_rail_control;
      standby_5v_rail_control <= next_standby_5v_rail_control;
      deep_sleep_3v3_rail_control <= next_deep_sleep_3v3_rail_control;
    end
  end

  // Bus answers one cycle after setup: pready registered high in access phase
  always_comb
  begin
    next_pready = psel && !penable;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    if (psel && !penable)
    begin
      next_prdata = 32'h0000_0000;
      case (word_addr)
        rcr_pkg::IO_RAIL_CONTROL_OFFSET:
          next_prdata[7:0] = io_rail_control & rcr_pkg::IO_RAIL_WRITE_MASK;
        rcr_pkg::STANDBY_5V_RAIL_CONTROL_OFFSET:
          next_prdata[7:0] = standby_5v_rail_control;
        rcr_pkg::DEEP_SLEEP_3V3_RAIL_CONTROL_OFFSET:
          next_prdata[7:0] = deep_sleep_3v3_rail_control;
        default:
          next_pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  rcr_mode_decode u_io_dec (
    .mode(io_rail_control[1:0]),
    .decoded(io_dec)
  );

  rcr_mode_decode u_s5_dec (
    .mode(standby_5v_rail_control.mode),
    .decoded(s5_dec)
  );

  rcr_mode_decode u_d3_dec (
    .mode(deep_sleep_3v3_rail_control.mode),
    .decoded(d3_dec)
  );

  // Regulator targets follow the registers and the synchronised standby level
  always_comb
  begin
    case (io_rail_control[5:4])
      2'h0: next_io_target = rcr_pkg::IO_MV_0975;
      2'h1: next_io_target = rcr_pkg::IO_MV_0950;
      2'h2: next_io_target = rcr_pkg::IO_MV_0875;
      default: next_io_target = rcr_pkg::IO_MV_0850;
    endcase
    next_io_pg_hold = 1'b0;
    if (io_rail_control[6] && standby_active)
    begin
      next_io_target = rcr_pkg::IO_MV_ZERO;
      next_io_pg_hold = 1'b1;
    end
    next_5v_offset = rail_offset(standby_5v_rail_control, standby_active);
    next_3v3_offset = rail_offset(deep_sleep_3v3_rail_control, standby_active);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      io_rail_target_mv <= rcr_pkg::IO_MV_0975;
      io_rail_power_good_hold <= 1'b0;
      standby_5v_offset_pct <= rcr_pkg::PCT_NOM;
      deep_sleep_3v3_offset_pct <= rcr_pkg::PCT_NOM;
      io_rail_mode_out <= '0;
      standby_5v_mode_out <= '0;
      deep_sleep_3v3_mode_out <= '0;
    end
    else
    begin
      io_rail_target_mv <= next_io_target;
      io_rail_power_good_hold <= next_io_pg_hold;
      standby_5v_offset_pct <= next_5v_offset;
      deep_sleep_3v3_offset_pct <= next_3v3_offset;
      io_rail_mode_out <= io_dec;
      standby_5v_mode_out <= s5_dec;
      deep_sleep_3v3_mode_out <= d3_dec;
    end
  end

  chk_reserved_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pslverr && $past(word_addr) == rcr_pkg::IO_RAIL_CONTROL_OFFSET
    |-> prdata[7] == 1'b0) else $error("reserved bit read nonzero");

  chk_decay_zero_volts: assert property (@(posedge pclk) disable iff (!presetn)
    io_rail_control[6] && standby_active |=> io_rail_target_mv == rcr_pkg::IO_MV_ZERO
    && io_rail_power_good_hold) else $error("decay not applied");

  chk_io_voltage_decode: assert property (@(posedge pclk) disable iff (!presetn)
    !io_rail_control[6] && io_rail_control[5:4] == 2'h1
    |=> io_rail_target_mv == rcr_pkg::IO_MV_0950) else $error("io select wrong");

  chk_exit_copy_mode: assert property (@(posedge pclk) disable iff (!presetn)
    exit_edge && !(access && pwrite) && standby_5v_rail_control.exit_mode != 2'h0
    |=> standby_5v_rail_control.mode == $past(standby_5v_rail_control.exit_mode))
    else $error("exit mode not copied");

  chk_exit_zero_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    exit_edge && !(access && pwrite) && io_rail_control[3:2] == 2'h0
    |=> $stable(io_rail_control[1:0])) else $error("mode changed on 00");

  chk_forced_pwm_flag: assert property (@(posedge pclk) disable iff (!presetn)
    standby_5v_rail_control.mode == rcr_pkg::MODE_FORCED_PWM
    |=> standby_5v_mode_out.forced_pulse_width_mode) else $error("forced pwm lost");

  chk_low_setpoint_apply: assert property (@(posedge pclk) disable iff (!presetn)
    standby_active && standby_5v_rail_control.low_setpoint == 2'h1
    |=> standby_5v_offset_pct == rcr_pkg::PCT_MINUS4) else $error("low set point wrong");

  chk_normal_restored: assert property (@(posedge pclk) disable iff (!presetn)
    !standby_active && deep_sleep_3v3_rail_control.voltage_select == 2'h0
    |=> deep_sleep_3v3_offset_pct == rcr_pkg::PCT_PLUS3) else $error("normal not restored");

  chk_exit_single_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    exit_edge |=> !exit_edge) else $error("exit edge repeated");
endmodule : rcr_bank

// ---- test/rcr_standby_host.sv ----
// Host platform model that drives the active-low standby pin.
// Assumes the bench calls its task from a process synchronous to pclk.
module rcr_standby_host (
  input wire logic pclk,
  output logic standby_request_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial standby_request_n = 1'b1;
  // Pin moves just after an edge and holds until the next call
  task automatic set_standby(input logic level_n);
    @(posedge pclk);
    standby_request_n <= level_n;
    repeat (8) @(posedge pclk);
  endtask : set_standby
endmodule : rcr_standby_host

// ---- test/test_rail_control_registers.sv ----
// Self-checking bench for the rail control register bank.
// Assumes zero-wait APB answers and the host model driving standby.
module test_rail_control_registers;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, standby_request_n, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [9:0] io_rail_target_mv;
  logic io_rail_power_good_hold;
  logic signed [3:0] standby_5v_offset_pct, deep_sleep_3v3_offset_pct;
  rcr_pkg::rcr_mode_type io_rail_mode_out, standby_5v_mode_out, deep_sleep_3v3_mode_out;
  int error_cnt = 0;
  int num_checks = 0;
  int cycles = 0;
  localparam logic [31:0] A_IO = 32'h000000C0;
  localparam logic [31:0] A_5V = 32'h000000C4;
  localparam logic [31:0] A_3V = 32'h000000C8;
  logic [9:0] io_mv [4] = '{10'h3CF, 10'h3B6, 10'h36B, 10'h352};
  logic signed [3:0] nrm [4] = '{4'sh3, 4'sh2, 4'sh0, -4'sh2};
  logic signed [3:0] low [4] = '{4'sh0, -4'sh4, -4'sh3, -4'sh2};
  logic [2:0] mdec [4] = '{3'h0, 3'h6, 3'h6, 3'h5};
  rcr_bank i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .standby_request_n(standby_request_n),
    .io_rail_target_mv(io_rail_target_mv), .io_rail_power_good_hold(io_rail_power_good_hold),
    .standby_5v_offset_pct(standby_5v_offset_pct),
    .deep_sleep_3v3_offset_pct(deep_sleep_3v3_offset_pct), .io_rail_mode_out(io_rail_mode_out),
    .standby_5v_mode_out(standby_5v_mode_out), .deep_sleep_3v3_mode_out(deep_sleep_3v3_mode_out));
  rcr_standby_host i_host (.pclk(pclk), .standby_request_n(standby_request_n));
  task automatic end_of_test;
    if (error_cnt == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr8(input logic [31:0] a, input logic [7:0] d);
    // Upper data bits carry a pattern that the bank must ignore
    apb(1'b1, a, {24'hA5A5A5, d});
    repeat (3) @(posedge pclk);
  endtask : wr8
  task automatic rd8(input string n, input logic [31:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(n, rd, {24'h000000, exp});
  endtask : rd8
  task automatic t_reset;
    rd8("io reset", A_IO, 8'h0A);
    rd8("5v reset", A_5V, 8'h2A);
    rd8("3v3 reset", A_3V, 8'h2A);
    chk("io mode", 32'(io_rail_mode_out), 32'h6);
    chk("io mv", 32'(io_rail_target_mv), 32'(io_mv[0]));
    chk("5v pct", 32'(standby_5v_offset_pct), 32'(nrm[2]));
  endtask : t_reset
  task automatic t_fields;
    wr8(A_IO, 8'hFF);
    rd8("io reserved", A_IO, 8'h7F);
    for (int v = 0; v < 4; v++)
    begin
      wr8(A_IO, {2'h0, 2'(v), 4'hA});
      wr8(A_5V, {2'h0, 2'(v), 4'hA});
      wr8(A_3V, {2'h0, 2'(v), 4'hA});
      chk("io mv", 32'(io_rail_target_mv), 32'(io_mv[v]));
      chk("5v pct", 32'(standby_5v_offset_pct), 32'(nrm[v]));
      chk("3v3 pct", 32'(deep_sleep_3v3_offset_pct), 32'(nrm[v]));
      wr8(A_IO, {6'h02, 2'(v)});
      wr8(A_5V, {6'h0A, 2'(v)});
      wr8(A_3V, {6'h0A, 2'(v)});
      chk("io mode", 32'(io_rail_mode_out), 32'(mdec[v]));
      chk("5v mode", 32'(standby_5v_mode_out), 32'(mdec[v]));
      chk("3v3 mode", 32'(deep_sleep_3v3_mode_out), 32'(mdec[v]));
    end
    apb(1'b1, 32'h000000CC, 32'h000000FF);
    chk("unmapped err", 32'(err), 32'h1);
    rd8("unmapped rd", 32'h000000CC, 8'h00);
  endtask : t_fields
  task automatic t_exit;
    logic [31:0] a [4] = '{A_IO, A_5V, A_3V, A_IO};
    logic [7:0] v [4] = '{8'h07, 8'h0C, 8'h01, 8'h03};
    logic [7:0] e [4] = '{8'h05, 8'h0F, 8'h01, 8'h03};
    for (int k = 0; k < 4; k++)
    begin
      wr8(a[k], v[k]);
      i_host.set_standby(1'b0);
      i_host.set_standby(1'b1);
      rd8("exit copy", a[k], e[k]);
    end
    wr8(A_5V, 8'h0D);
    repeat (20) @(posedge pclk);
    rd8("single copy", A_5V, 8'h0D);
  endtask : t_exit
  task automatic t_low;
    for (int lv = 0; lv < 4; lv++)
    begin
      wr8(A_5V, {2'(lv), 6'h2A});
      wr8(A_3V, {2'(lv), 6'h3A});
      i_host.set_standby(1'b0);
      chk("5v low", 32'(standby_5v_offset_pct), 32'(lv == 0 ? nrm[2] : low[lv]));
      chk("3v3 low", 32'(deep_sleep_3v3_offset_pct), 32'(lv == 0 ? nrm[3] : low[lv]));
      i_host.set_standby(1'b1);
      chk("5v back", 32'(standby_5v_offset_pct), 32'(nrm[2]));
      chk("3v3 back", 32'(deep_sleep_3v3_offset_pct), 32'(nrm[3]));
    end
  endtask : t_low
  task automatic t_decay;
    wr8(A_IO, 8'h0B);
    wr8(A_IO, 8'h0A);
    // Settle time after forced PWM before decay is allowed
    repeat (500) @(posedge pclk);
    wr8(A_IO, 8'h4A);
    i_host.set_standby(1'b0);
    chk("decay mv", 32'(io_rail_target_mv), 32'h0);
    chk("decay pg", 32'(io_rail_power_good_hold), 32'h1);
    i_host.set_standby(1'b1);
    chk("wake mv", 32'(io_rail_target_mv), 32'(io_mv[0]));
    wr8(A_IO, 8'h1A);
    i_host.set_standby(1'b0);
    chk("hold mv", 32'(io_rail_target_mv), 32'(io_mv[1]));
    chk("hold pg", 32'(io_rail_power_good_hold), 32'h0);
    i_host.set_standby(1'b1);
  endtask : t_decay
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      end_of_test();
    end
  end
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_fields();
    t_exit();
    t_low();
    t_decay();
    end_of_test();
  end
endmodule : test_rail_control_registers
